// ### dv/pwmpcs_chk.sv
// Purpose: Port-level checks for the PWM period and status block
// Assumes: Bound to pwmpcs_top, one clock domain, 1-wait APB slave
// Notes: Flash check assumes the bench's flash half period of 8
`timescale 1ns/10ps
module pwmpcs_chk #(
  parameter STARTUP_CYC = 20, // Start-up cycles
  parameter FLASH_CYC = 8 // Flash half period
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire [7:0] paddr, // APB address
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire pwm_out, // Switch drive
  input wire out_led, // Output indicator
  input wire led_red, // Status red
  input wire led_green // Status green
);
  // Window in which start-up must end
  localparam int BOOT_MIN = STARTUP_CYC - 2;
  localparam int BOOT_MAX = STARTUP_CYC + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  led_follow_a: assert property (out_led == pwm_out)
    else $error("output indicator differs from drive");
  ready_wait_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("ready not one cycle after one wait");
  err_unmapped_a: assert property (pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  prdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  boot_orange_a: assert property ($fell(rst) |=> (led_red && led_green)[*8])
    else $error("no orange at start-up");
  boot_green_a: assert property ($fell(rst) |-> ##[BOOT_MIN:BOOT_MAX] (led_green && !led_red))
    else $error("start-up did not end in green");
  boot_quiet_a: assert property (led_red && led_green |-> !pwm_out)
    else $error("drive active during start-up");
  flash_green_a: assert property ($rose(led_green) && !led_red |-> led_green[*8])
    else $error("green phase shorter than half period");
  // Main scenarios
  cover property ($fell(led_green) && !led_red);
  cover property (pready && pslverr);
  cover property (led_red && !led_green && pwm_out);
endmodule
bind pwmpcs_top pwmpcs_chk #(.STARTUP_CYC(STARTUP_CYC), .FLASH_CYC(FLASH_CYC)) u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .out_led(out_led),
  .led_red(led_red), .led_green(led_green));

// ### dv/pwmpcs_load.sv
// Purpose: Switched load with fuse and open-wire sensing
// Assumes: Bench chooses the fault through open_en and fuse_en
// Notes: Open wire is only seen while the switch conducts
`timescale 1ns/10ps
module pwmpcs_load (
  input wire clk, // System clock
  input wire pwm_out, // Switch drive
  input wire open_en, // Break the load wire
  input wire fuse_en, // Blow the fuse
  output reg fuse_blown = 1'b0, // Fuse sense
  output reg open_load = 1'b0 // Open load sense
);
  // Current sense needs the switch on, so open state holds while off
  always @(posedge clk)
  begin
    fuse_blown <= fuse_en;
    if (pwm_out)
      open_load <= open_en;
  end
endmodule

// ### dv/pwmpcs_top_tb.sv
// Purpose: Self-checking bench for the PWM period and status block
// Assumes: Shortened start-up and flash counts
// Notes: Period is cut to 7 ticks to keep the run short
`timescale 1ns/10ps
`include "pwmpcs_map.vh"
module pwmpcs_top_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, fuse_blown, open_load, pwm_out, out_led, led_red, led_green;
  logic open_en = 1'b0, fuse_en = 1'b0; // Fault requests to the load
  int err_total = 0, tests_run = 0;
  always #5 clk = ~clk;
  pwmpcs_top #(.STARTUP_CYC(20), .FLASH_CYC(8)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_blown(fuse_blown), .open_load(open_load),
    .pwm_out(pwm_out), .out_led(out_led), .led_red(led_red), .led_green(led_green));
  pwmpcs_load u_load (.clk(clk), .pwm_out(pwm_out), .open_en(open_en), .fuse_en(fuse_en),
    .fuse_blown(fuse_blown), .open_load(open_load));
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail("no ready");
      tally_and_finish();
    end
  endtask
  // Read until the masked value appears, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n = 0;
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== e && n < 30)
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    chk(rd & m, e, "register poll");
    if (n >= 30)
      tally_and_finish();
  endtask
  task automatic wait_led(input logic r, input logic g, input int lim);
    int n = 0;
    while (!(led_red === r && led_green === g) && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    tests_run++;
    if (n >= lim)
    begin
      fail("indicator pattern missing");
      tally_and_finish();
    end
  endtask
  // Cycles for which the drive keeps level v
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (pwm_out === v && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      fail("drive stuck");
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_boot;
    wait_led(1'b1, 1'b1, 3);
    wait_led(1'b0, 1'b1, 40);
    apb(1'b0, `PWMPCS_A_ACT_PER, 32'h0);
    chk(rd, 32'd15360, "default period");
    poll(`PWMPCS_A_HZ, 32'hffffffff, 32'd100);
    poll(`PWMPCS_A_STATUS, 32'h3, 32'h1);
    $display("test boot done");
  endtask
  task automatic t_normal;
    logic [31:0] v;
    apb(1'b0, `PWMPCS_A_PER_LO, 32'h0);
    v = rd;
    apb(1'b1, `PWMPCS_A_PER_LO, 32'h5);
    apb(1'b1, `PWMPCS_A_HZ, 32'd200);
    repeat (30) @(posedge clk);
    apb(1'b0, `PWMPCS_A_PER_LO, 32'h0);
    chk(rd, v, "period taken outside config");
    apb(1'b1, 8'h1c, 32'h1);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er} | rd, 32'h1, "unmapped read");
    $display("test normal done");
  endtask
  task automatic t_cfg_hz;
    int hz [5] = '{500, 2, 1000, 1, 1001};
    int c = 0, n = 0;
    apb(1'b1, `PWMPCS_A_DUTY, 32'h00ffffff);
    apb(1'b1, `PWMPCS_A_CTRL, 32'h1);
    poll(`PWMPCS_A_CTRL, 32'h1, 32'h1);
    repeat (300)
    begin
      @(posedge clk);
      n += (pwm_out !== 1'b0);
    end
    chk(n, 0, "drive active in config");
    wait_led(1'b0, 1'b0, 30);
    wait_led(1'b0, 1'b1, 30);
    foreach (hz[i])
    begin
      apb(1'b1, `PWMPCS_A_HZ, hz[i]);
      if (hz[i] >= 2 && hz[i] <= 1000)
        c = (1536000 + hz[i] / 2) / hz[i];
      repeat (30) @(posedge clk);
      apb(1'b0, `PWMPCS_A_PER_LO, 32'h0);
      chk(rd, c % 65536, "hertz low part");
      apb(1'b0, `PWMPCS_A_PER_HI, 32'h0);
      chk(rd, c / 65536, "hertz high part");
    end
    $display("test config done");
  endtask
  task automatic t_save;
    apb(1'b1, `PWMPCS_A_PER_LO, 32'h7);
    apb(1'b1, `PWMPCS_A_PER_HI, 32'h0);
    apb(1'b1, `PWMPCS_A_CTRL, 32'h2);
    apb(1'b1, `PWMPCS_A_CTRL, 32'h1);
    wait_led(1'b1, 1'b1, 10);
    wait_led(1'b0, 1'b1, 40);
    apb(1'b0, `PWMPCS_A_ACT_PER, 32'h0);
    chk(rd, 32'h7, "stored period reload");
    poll(`PWMPCS_A_HZ, 32'hffffffff, 32'd1536000 / 7);
    $display("test save done");
  endtask
  task automatic t_pwm;
    int hi, lo;
    apb(1'b1, `PWMPCS_A_DUTY, 32'h3);
    run_len(1'b1, lo);
    run_len(1'b0, lo);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    chk(hi >= 195 && hi <= 196, 1, "on time of 3 ticks");
    chk(hi + lo >= 455 && hi + lo <= 457, 1, "period of 7 ticks");
    $display("test pwm done");
  endtask
  task automatic t_fault;
    int n = 0;
    poll(`PWMPCS_A_STATUS, 32'h80, 32'h80);
    open_en <= 1'b1;
    wait_led(1'b1, 1'b0, 3000);
    wait_led(1'b0, 1'b0, 40);
    // Finish the run in progress, skip the low run, then time a whole on run
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(n >= 195 && n <= 196, 1, "drive under open load");
    fuse_en <= 1'b1;
    poll(`PWMPCS_A_STATUS, 32'h4, 32'h4);
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      n += (led_red !== 1'b1);
    end
    chk(n, 0, "fuse red not steady");
    open_en <= 1'b0;
    fuse_en <= 1'b0;
    wait_led(1'b0, 1'b1, 3000);
    apb(1'b1, `PWMPCS_A_DUTY, 32'h7);
    poll(`PWMPCS_A_STATUS, 32'h80, 32'h0);
    open_en <= 1'b1;
    repeat (30)
    begin
      apb(1'b0, `PWMPCS_A_STATUS, 32'h0);
      chk(rd & 32'h8, 32'h0, "fault sampled out of window");
    end
    open_en <= 1'b0;
    $display("test fault done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_normal();
    t_cfg_hz();
    t_save();
    t_pwm();
    t_fault();
    tally_and_finish();
  end
endmodule

// ### rtl/pwmpcs_map.vh
// Purpose: Constants for the PWM period, configuration and status block
// Assumes: 100 MHz system clock, 32-bit APB register bus
// Notes: Byte addresses, field positions, reset values and timing figures
`ifndef PWMPCS_MAP_VH
`define PWMPCS_MAP_VH

// Register byte addresses
`define PWMPCS_A_CTRL 8'h00
`define PWMPCS_A_PER_LO 8'h04
`define PWMPCS_A_PER_HI 8'h08
`define PWMPCS_A_HZ 8'h0c
`define PWMPCS_A_DUTY 8'h10
`define PWMPCS_A_STATUS 8'h14
`define PWMPCS_A_ACT_PER 8'h18

// Control register bits (write one to act)
`define PWMPCS_CTRL_CFG_TOGGLE 0
`define PWMPCS_CTRL_SAVE 1

// Status register bits
`define PWMPCS_ST_FUSE 2
`define PWMPCS_ST_OPEN 3
`define PWMPCS_ST_BUSY 4
`define PWMPCS_ST_RED 5
`define PWMPCS_ST_GREEN 6
`define PWMPCS_ST_VALID 7

// Widths
`define PWMPCS_LO_W 16
`define PWMPCS_HI_W 8
`define PWMPCS_PER_W 24

// Timer tick rate and system rate, both in kHz
`define PWMPCS_TICK_KHZ 17'h00600
`define PWMPCS_SYS_KHZ 17'h186a0
// Tick rate in Hz, dividend for period and frequency
`define PWMPCS_TICK_HZ 24'h177000

// Frequency limits in Hz
`define PWMPCS_HZ_MIN 32'h00000002
`define PWMPCS_HZ_MAX 32'h000003e8

// Factory default period: 100 Hz gives 15360 counts
`define PWMPCS_DEF_LO 16'h3c00
`define PWMPCS_DEF_HI 8'h00

// Fault window: duty between 10% and 90% of the period
`define PWMPCS_PCT_LO 28'h000000a
`define PWMPCS_PCT_HI 28'h0000009

// Start-up time and indicator flash half period, in ms
`define PWMPCS_STARTUP_MS 32'h00000064
`define PWMPCS_FLASH_MS 32'h000000fa
`define PWMPCS_CYC_PER_MS 32'h000186a0

`endif

// ### rtl/pwmpcs_top.v
// Purpose: PWM carrier period timing, period configuration and status indicators
// Assumes: APB slave with one wait state; fault sense inputs synchronous to clk
// Notes: Configuration store is a two-entry array reset to factory values
// How it works
// - Period counter advances on 1.536 MHz ticks
// - Period is 16-bit low plus high part
// - Hertz command derives period by rounded division
// - Frequency changes accepted only in configuration mode
// - Hertz commands outside 2..1000 are ignored
// - Store keeps low and high as entries
// - Hertz readback shows integer part only
// - Output indicator follows switch drive signal
// - Output indicator ignores load faults
// - Orange during start-up, then steady green
// - Green, flash green, red, flash red
// - Illegal controller state shows dark indicator
// - Faults sampled only at 10..90% duty
// - Faults never stop the PWM output
// - Start-up loads period from store
// - Configuration mode forces zero duty
// - Unconfigured store defaults to 100 Hz
// - Leaving configuration restarts and reloads store
// - Save writes pending period into store
`timescale 1ns/10ps
`include "pwmpcs_map.vh"

module pwmpcs_top #(
  parameter STARTUP_CYC = `PWMPCS_STARTUP_MS * `PWMPCS_CYC_PER_MS, // Start-up cycles
  parameter FLASH_CYC = `PWMPCS_FLASH_MS * `PWMPCS_CYC_PER_MS // Flash half period
) (
  input wire clk, // System clock 100 MHz
  input wire rst, // Synchronous reset, active high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire fuse_blown, // Fuse sense, high when blown
  input wire open_load, // Open load sense, high when open
  output reg pwm_out, // Power switch drive
  output reg out_led, // Output indicator
  output reg led_red, // Status indicator red
  output reg led_green // Status indicator green
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam ST_BOOT = 2'd0; // Start-up and self-test
  localparam ST_NORM = 2'd1; // Normal operation
  localparam ST_CFG = 2'd2; // Configuration mode
  reg [1:0] state_q; // Controller state
  reg [31:0] boot_cnt_q; // Start-up timer
  reg [31:0] flash_cnt_q; // Flash timer
  reg flash_q; // Flash phase
  reg [16:0] acc_q; // Tick phase accumulator
  reg tick_q; // 1.536 MHz tick
  reg [`PWMPCS_PER_W-1:0] cnt_q; // Period counter
  reg [`PWMPCS_PER_W-1:0] act_per_q; // Active period
  reg [`PWMPCS_LO_W-1:0] pend_lo_q; // Pending low part
  reg [`PWMPCS_HI_W-1:0] pend_hi_q; // Pending high part
  reg pend_new_q; // Pending period awaits boundary
  reg [`PWMPCS_PER_W-1:0] store_q [0:1]; // Configuration store entries
  reg [`PWMPCS_PER_W-1:0] duty_q; // Duty threshold in counts
  reg fuse_q; // Qualified fuse fault
  reg open_q; // Qualified open load fault
  reg [`PWMPCS_PER_W-1:0] hz_rd_q; // Integer hertz of active period
  reg hz_dirty_q; // Readback needs recompute
  reg hz_req_q; // Hertz command waiting
  reg [`PWMPCS_PER_W-1:0] hz_cmd_q; // Requested hertz
  reg div_busy_q; // Divider running
  reg div_op_q; // 0 hertz to period, 1 period to hertz
  reg [`PWMPCS_PER_W-1:0] div_num_q; // Dividend, shifts into quotient
  reg [`PWMPCS_PER_W-1:0] div_den_q; // Divisor
  reg [`PWMPCS_PER_W-1:0] div_rem_q; // Partial remainder
  reg [4:0] div_cnt_q; // Steps left
  wire apb_take; // Transfer completes this edge
  wire wr; // Write completes
  wire boundary; // Last tick of a period
  wire fault_valid; // Duty inside fault window
  wire [24:0] rem_sh; // Shifted remainder
  wire rem_ge; // Subtract step succeeds
  wire [`PWMPCS_PER_W-1:0] per_full; // Combined pending period
  wire [17:0] acc_sum; // Accumulator next sum
  wire [27:0] duty_x10; // Duty times ten
  wire [27:0] per_x1; // Period widened
  wire [27:0] per_x9; // Period times nine
  reg mapped; // Address decodes
  reg [31:0] rd_val; // Read mux

  // Combine high and low parts of a period
  function [`PWMPCS_PER_W-1:0] join_per;
    input [`PWMPCS_HI_W-1:0] hi;
    input [`PWMPCS_LO_W-1:0] lo;
    begin
      join_per = {hi, lo};
    end
  endfunction

  assign apb_take = psel & penable & pready;
  assign wr = apb_take & pwrite & mapped;
  assign per_full = join_per(pend_hi_q, pend_lo_q);
  assign acc_sum = {1'b0, acc_q} + {1'b0, `PWMPCS_TICK_KHZ};
  assign boundary = tick_q & ((cnt_q + 24'h000001) >= act_per_q);
  assign rem_sh = {div_rem_q, div_num_q[`PWMPCS_PER_W-1]};
  assign rem_ge = rem_sh >= {1'b0, div_den_q};
  assign duty_x10 = {4'h0, duty_q} * `PWMPCS_PCT_LO;
  assign per_x1 = {4'h0, act_per_q};
  assign per_x9 = per_x1 * `PWMPCS_PCT_HI;
  assign fault_valid = (duty_x10 >= per_x1) && (duty_x10 <= per_x9);

  ////////////////////////////////////////////////////////////////////////////
  // Tick generator: fractional accumulator gives 1.536 MHz from 100 MHz
  always @(posedge clk)
  begin
    if (rst)
    begin
      acc_q <= 17'h00000;
      tick_q <= 1'b0;
    end
    else if (acc_sum >= {1'b0, `PWMPCS_SYS_KHZ})
    begin
      acc_q <= acc_sum[16:0] - `PWMPCS_SYS_KHZ;
      tick_q <= 1'b1;
    end
    else
    begin
      acc_q <= acc_sum[16:0];
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller state, start-up timer, configuration store
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_BOOT;
      boot_cnt_q <= 32'h00000000;
      store_q[0] <= {8'h00, `PWMPCS_DEF_LO};
      store_q[1] <= {16'h0000, `PWMPCS_DEF_HI};
    end
    else
    begin
      case (state_q)
        ST_BOOT:
        begin
          // Orange while self-test runs, then go normal
          if (boot_cnt_q >= STARTUP_CYC - 1)
          begin
            state_q <= ST_NORM;
            boot_cnt_q <= 32'h00000000;
          end
          else
          begin
            boot_cnt_q <= boot_cnt_q + 32'h00000001;
          end
        end
        ST_NORM:
        begin
          if (wr && paddr == `PWMPCS_A_CTRL && pwdata[`PWMPCS_CTRL_CFG_TOGGLE])
          begin
            state_q <= ST_CFG;
          end
        end
        ST_CFG:
        begin
          if (wr && paddr == `PWMPCS_A_CTRL && pwdata[`PWMPCS_CTRL_SAVE])
          begin
            store_q[0] <= {8'h00, pend_lo_q};
            store_q[1] <= {16'h0000, pend_hi_q};
          end
          if (wr && paddr == `PWMPCS_A_CTRL && pwdata[`PWMPCS_CTRL_CFG_TOGGLE])
          begin
            state_q <= ST_BOOT;
          end
        end
        default:
        begin
          // Illegal code restarts the controller
          state_q <= ST_BOOT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending and active period, period counter
  always @(posedge clk)
  begin
    if (rst)
    begin
      pend_lo_q <= `PWMPCS_DEF_LO;
      pend_hi_q <= `PWMPCS_DEF_HI;
      pend_new_q <= 1'b0;
      act_per_q <= join_per(`PWMPCS_DEF_HI, `PWMPCS_DEF_LO);
      cnt_q <= 24'h000000;
    end
    else if (state_q == ST_BOOT)
    begin
      // Load from the store while starting up
      pend_lo_q <= store_q[0][`PWMPCS_LO_W-1:0];
      pend_hi_q <= store_q[1][`PWMPCS_HI_W-1:0];
      act_per_q <= join_per(store_q[1][`PWMPCS_HI_W-1:0], store_q[0][`PWMPCS_LO_W-1:0]);
      pend_new_q <= 1'b0;
      cnt_q <= 24'h000000;
    end
    else
    begin
      if (div_busy_q && !div_op_q && div_cnt_q == 5'd1 && state_q == ST_CFG)
      begin
        // Rounded quotient becomes the pending period dropped once out of config
        pend_lo_q <= {div_num_q[`PWMPCS_LO_W-2:0], rem_ge};
        pend_hi_q <= div_num_q[`PWMPCS_PER_W-2:`PWMPCS_LO_W-1];
        pend_new_q <= 1'b1;
      end
      else if (wr && state_q == ST_CFG && paddr == `PWMPCS_A_PER_LO)
      begin
        pend_lo_q <= pwdata[`PWMPCS_LO_W-1:0];
      end
      else if (wr && state_q == ST_CFG && paddr == `PWMPCS_A_PER_HI)
      begin
        pend_hi_q <= pwdata[`PWMPCS_HI_W-1:0];
        pend_new_q <= 1'b1; // High write completes the pair
      end
      else if (boundary)
      begin
        pend_new_q <= 1'b0;
      end
      if (boundary)
      begin
        cnt_q <= 24'h000000;
        if (pend_new_q)
        begin
          act_per_q <= per_full;
        end
      end
      else if (tick_q)
      begin
        cnt_q <= cnt_q + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared restoring divider: hertz command and hertz readback
  always @(posedge clk)
  begin
    if (rst)
    begin
      div_busy_q <= 1'b0;
      div_op_q <= 1'b0;
      div_num_q <= 24'h000000;
      div_den_q <= 24'h000000;
      div_rem_q <= 24'h000000;
      div_cnt_q <= 5'd0;
      hz_rd_q <= 24'h000000;
    end
    else if (div_busy_q)
    begin
      div_num_q <= {div_num_q[`PWMPCS_PER_W-2:0], rem_ge};
      div_rem_q <= rem_ge ? (rem_sh[23:0] - div_den_q) : rem_sh[23:0];
      div_cnt_q <= div_cnt_q - 5'd1;
      if (div_cnt_q == 5'd1)
      begin
        div_busy_q <= 1'b0;
        if (div_op_q)
        begin
          hz_rd_q <= {div_num_q[`PWMPCS_PER_W-2:0], rem_ge}; // Truncated
        end
      end
    end
    else if (hz_req_q)
    begin
      // Add half the divisor so the quotient rounds to nearest
      div_busy_q <= 1'b1;
      div_op_q <= 1'b0;
      div_num_q <= `PWMPCS_TICK_HZ + {1'b0, hz_cmd_q[`PWMPCS_PER_W-1:1]};
      div_den_q <= hz_cmd_q;
      div_rem_q <= 24'h000000;
      div_cnt_q <= 5'd24;
    end
    else if (hz_dirty_q && act_per_q != 24'h000000)
    begin
      div_busy_q <= 1'b1;
      div_op_q <= 1'b1;
      div_num_q <= `PWMPCS_TICK_HZ;
      div_den_q <= act_per_q;
      div_rem_q <= 24'h000000;
      div_cnt_q <= 5'd24;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hertz command capture and readback refresh flag
  always @(posedge clk)
  begin
    if (rst)
    begin
      hz_req_q <= 1'b0;
      hz_cmd_q <= 24'h000000;
      hz_dirty_q <= 1'b1;
    end
    else
    begin
      if (wr && state_q == ST_CFG && paddr == `PWMPCS_A_HZ &&
          pwdata >= `PWMPCS_HZ_MIN && pwdata <= `PWMPCS_HZ_MAX)
      begin
        hz_req_q <= 1'b1;
        hz_cmd_q <= pwdata[`PWMPCS_PER_W-1:0];
      end
      else if (!div_busy_q)
      begin
        hz_req_q <= 1'b0;
      end
      // Active period change wins over the refresh start
      if (state_q == ST_BOOT || (boundary && pend_new_q))
      begin
        hz_dirty_q <= 1'b1;
      end
      else if (!div_busy_q && !hz_req_q)
      begin
        hz_dirty_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty register, fault qualification, PWM drive
  always @(posedge clk)
  begin
    if (rst)
    begin
      duty_q <= 24'h000000;
      fuse_q <= 1'b0;
      open_q <= 1'b0;
      pwm_out <= 1'b0;
      out_led <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `PWMPCS_A_DUTY)
      begin
        duty_q <= pwdata[`PWMPCS_PER_W-1:0];
      end
      if (fault_valid)
      begin
        fuse_q <= fuse_blown;
        open_q <= open_load;
      end
      // Faults take no part in the drive zero duty in configuration
      pwm_out <= (state_q == ST_NORM) && (cnt_q < duty_q);
      out_led <= (state_q == ST_NORM) && (cnt_q < duty_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status indicator with flash timer
  always @(posedge clk)
  begin
    if (rst)
    begin
      flash_cnt_q <= 32'h00000000;
      flash_q <= 1'b0;
      led_red <= 1'b0;
      led_green <= 1'b0;
    end
    else
    begin
      if (flash_cnt_q >= FLASH_CYC - 1)
      begin
        flash_cnt_q <= 32'h00000000;
        flash_q <= ~flash_q;
      end
      else
      begin
        flash_cnt_q <= flash_cnt_q + 32'h00000001;
      end
      case (state_q)
        ST_BOOT:
        begin
          led_red <= 1'b1;
          led_green <= 1'b1;
        end
        ST_CFG:
        begin
          led_red <= 1'b0;
          led_green <= flash_q;
        end
        ST_NORM:
        begin
          led_red <= fuse_q | (open_q & flash_q);
          led_green <= ~fuse_q & ~open_q;
        end
        default:
        begin
          led_red <= 1'b0;
          led_green <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and decode
  always @*
  begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      `PWMPCS_A_CTRL: rd_val = {31'h00000000, state_q == ST_CFG};
      `PWMPCS_A_PER_LO: rd_val = {16'h0000, pend_lo_q};
      `PWMPCS_A_PER_HI: rd_val = {24'h000000, pend_hi_q};
      `PWMPCS_A_HZ: rd_val = {8'h00, hz_rd_q};
      `PWMPCS_A_DUTY: rd_val = {8'h00, duty_q};
      `PWMPCS_A_STATUS: rd_val = {24'h000000, fault_valid, led_green, led_red,
                                   div_busy_q | hz_req_q, open_q, fuse_q, state_q};
      `PWMPCS_A_ACT_PER: rd_val = {8'h00, act_per_q};
      default: mapped = 1'b0;
    endcase
  end

  // APB slave: one wait state, data and error set with pready
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_val : 32'h00000000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

endmodule
